/* pkg/pst_consts.svh */
// register indices, field positions and reset values of the sequencer
`ifndef PST_CONSTS_SVH
`define PST_CONSTS_SVH
`define PST_IDX_IND 3'h0
`define PST_IDX_CNT 3'h1
`define PST_IDX_PCL 3'h2
`define PST_IDX_STAT 3'h3
`define PST_IDX_PTR 3'h4
`define PST_IDX_TSET 3'h5
`define PST_IDX_CMD 3'h6
`define PST_IDX_PCF 3'h7
`define PST_LOC_CNT 6'h01
`define PST_LOC_PCL 6'h02
`define PST_LOC_STAT 6'h03
`define PST_LOC_PTR 6'h04
`define PST_TS_SRC 5
`define PST_TS_EDGE 4
`define PST_TS_ASSIGN 3
`define PST_TS_PSR 2:0
`define PST_CMD_OP 12:10
`define PST_CMD_ARG 9:0
`define PST_ST_OVF 0
`define PST_PC_RST_T0 10'h3FF
`define PST_PC_RST_T1 10'h000
`define PST_TSET_RST 8'h00
`define PST_PTR_HI 2'h3
`define PST_STK_DEPTH 3'h5
`define PST_CYC_PLAIN 2'h1
`define PST_CYC_BRANCH 2'h2
`define PST_RESP_OKAY 2'h0
`define PST_RESP_SLVERR 2'h2
`endif

/* pkg/pst_pkg.sv */
// types of the program sequencer and timer
package pst_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } pst_st_e;
  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_JUMP = 3'h1,
    OP_CALL = 3'h2,
    OP_RET = 3'h3,
    OP_RETLIT = 3'h4,
    OP_RETINT = 3'h5,
    OP_PCWR = 3'h6,
    OP_PCADD = 3'h7
  } pst_op_e;
  typedef logic [9:0] pst_pc_t;
  typedef struct packed {
    pst_st_e st;
    logic [2:0] divCnt;
    logic [1:0] cyc;
    pst_op_e op;
    logic [9:0] arg;
    logic [9:0] pc;
    logic [4:0][9:0] stk;
    logic [2:0] sp;
    logic [7:0] lit;
    logic [7:0] cnt;
    logic [7:0] pre;
    logic [7:0] tset;
    logic [5:0] ptr;
    logic ovf;
    logic ovfPulse;
    logic [2:0] pinSync;
    logic [63:0][7:0] ram;
    logic awRdy;
    logic wRdy;
    logic awHeld;
    logic wHeld;
    logic [2:0] awIdx;
    logic awBad;
    logic [15:0] wData;
    logic [1:0] wStb;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } pst_state_s;
endpackage

/* rtl/pst_core.sv */
// program sequencer, return stack and real-time counter with axi4-lite
//
// Overview of operation
// RULE1: indirect port accesses the location addressed by the pointer
// RULE2: counter is eight bits and flags an event on rollover
// RULE3: counter counts instruction cycles or selected pin edge
// RULE4: software reads and writes the counter like any location
// RULE5: assign bit clear routes the prescaler to the counter
// RULE6: only a counter write clears the prescaler count
// RULE7: program counter and stack entries are ten bits
// RULE8: one page of 1024 words addressed by the program counter
// RULE9: core type one resets the program counter to zero
// RULE10: core type zero resets the program counter to 3FF
// RULE11: jump loads its ten-bit target into the program counter
// RULE12: call pushes next address and loads its target
// RULE13: all three returns load the top entry and pop it
// RULE14: stack holds five levels
// RULE15: type one with enhanced jump clears bits 8 and 9 on writes
// RULE16: type one without enhanced jump adds with full carry
// RULE17: instruction cycle is clock divided by 2, 4 or 8
// RULE18: program counter changes cost one extra instruction cycle
// RULE19: pointer uses six low bits; upper two read as one
// RULE20: ratio field 000..111 divides by 2 up to 256
// RULE21: call on a full stack overwrites the oldest entry silently
// RULE22: counter wraps FF to 00 and raises the event there
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "pst_consts.svh"
module pst_core #(
  parameter bit CORE_TYPE = 1'b1,
  parameter bit ENH_JUMP = 1'b1,
  parameter int CLK_DIV = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tccPin,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output pst_pkg::pst_pc_t pcOut,
  output logic ovfEvent,
  output logic busy
);
  import pst_pkg::*;

  pst_state_s q_reg;
  pst_state_s q_next;
  logic tick;
  logic rise;
  logic fall;
  logic pulse;
  logic cntInc;
  logic cntWr;
  logic doExec;
  logic launch;
  logic wEn;
  logic statClr;
  logic [5:0] wLoc;
  logic [7:0] wDat;
  logic [7:0] mask;
  logic [7:0] statByte;
  logic [9:0] nArg;
  logic [9:0] sum;
  logic [9:0] retTgt;
  logic [2:0] spUp;
  logic [2:0] spDn;
  logic [31:0] rdVal;
  pst_op_e nOp;

  // circular pointer, so a sixth call quietly replaces the oldest
  function automatic logic [2:0] spStep(input logic [2:0] p,
                                        input logic up);
    if (up)
      spStep = (p == `PST_STK_DEPTH - 3'h1) ? 3'h0 : p + 3'h1; // RULE21
    else
      spStep = (p == 3'h0) ? `PST_STK_DEPTH - 3'h1 : p - 3'h1;
  endfunction

  function automatic logic [9:0] pcFix(input logic [9:0] v);
    pcFix = (CORE_TYPE && ENH_JUMP) ? {2'h0, v[7:0]} : v; // RULE15
  endfunction

  // location 0 reads as zero: the port cannot point at itself
  function automatic logic [7:0] rdLoc(input logic [5:0] a);
    case (a)
      6'h00: rdLoc = 8'h00;
      `PST_LOC_CNT: rdLoc = q_reg.cnt; // RULE4
      `PST_LOC_PCL: rdLoc = q_reg.pc[7:0];
      `PST_LOC_STAT: rdLoc = statByte;
      `PST_LOC_PTR: rdLoc = {`PST_PTR_HI, q_reg.ptr}; // RULE19
      default: rdLoc = q_reg.ram[a];
    endcase
  endfunction

  always_comb begin
    q_next = q_reg;
    q_next.ovfPulse = 1'b0;
    wEn = 1'b0;
    wLoc = 6'h00;
    wDat = q_reg.wData[7:0];
    launch = 1'b0;
    statClr = 1'b0;
    nOp = OP_NOP;
    nArg = 10'h000;
    doExec = 1'b0;
    cntInc = 1'b0;
    rdVal = 32'h0000_0000;
    statByte = {1'b0, q_reg.sp, ENH_JUMP, CORE_TYPE,
                q_reg.st == ST_EXEC, q_reg.ovf};

    // instruction cycle strobe
    tick = q_reg.divCnt == 3'(CLK_DIV - 1); // RULE17
    q_next.divCnt = tick ? 3'h0 : q_reg.divCnt + 3'h1;

    // pin sync; edges are taken from the second and third stages
    q_next.pinSync = {q_reg.pinSync[1:0], tccPin};
    rise = q_reg.pinSync[1] & ~q_reg.pinSync[2];
    fall = ~q_reg.pinSync[1] & q_reg.pinSync[2];

    // write channel
    if (q_reg.bValid && s_axi_bready)
      q_next.bValid = 1'b0;
    if (s_axi_awvalid && q_reg.awRdy) begin
      q_next.awHeld = 1'b1;
      q_next.awIdx = s_axi_awaddr[4:2];
      q_next.awBad = s_axi_awaddr[31:5] != 27'h0;
    end
    if (s_axi_wvalid && q_reg.wRdy) begin
      q_next.wHeld = 1'b1;
      q_next.wData = s_axi_wdata[15:0];
      q_next.wStb = s_axi_wstrb[1:0];
    end
    if (q_reg.awHeld && q_reg.wHeld && !q_reg.bValid) begin
      q_next.awHeld = 1'b0;
      q_next.wHeld = 1'b0;
      q_next.bValid = 1'b1;
      q_next.bResp = q_reg.awBad ? `PST_RESP_SLVERR : `PST_RESP_OKAY;
      if (!q_reg.awBad && q_reg.wStb[0]) begin
        case (q_reg.awIdx)
          `PST_IDX_IND: begin
            wEn = 1'b1;
            wLoc = q_reg.ptr; // RULE1
          end
          `PST_IDX_TSET: q_next.tset = wDat;
          `PST_IDX_CMD: begin
            // a command needs both low bytes, a half one is dropped
            if (q_reg.wStb[1]) begin
              launch = 1'b1;
              nOp = pst_op_e'(q_reg.wData[`PST_CMD_OP]);
              nArg = q_reg.wData[`PST_CMD_ARG];
            end
          end
          `PST_IDX_PCF: ;
          default: begin
            wEn = 1'b1;
            wLoc = {3'h0, q_reg.awIdx};
          end
        endcase
      end
    end
    cntWr = wEn && wLoc == `PST_LOC_CNT;

    // counter and shared prescaler
    mask = 8'hFF >> (3'h7 - q_reg.tset[`PST_TS_PSR]); // RULE20
    pulse = q_reg.tset[`PST_TS_SRC] ?
            (q_reg.tset[`PST_TS_EDGE] ? fall : rise) : tick; // RULE3
    if (pulse && !cntWr) begin
      if (q_reg.tset[`PST_TS_ASSIGN]) begin
        // prescaler is bypassed and holds its count, counter takes every pulse
        cntInc = 1'b1;
      end else begin
        q_next.pre = q_reg.pre + 8'h01; // RULE5
        cntInc = (q_reg.pre & mask) == mask;
      end
    end
    if (cntInc) begin
      q_next.cnt = q_reg.cnt + 8'h01; // RULE22
      if (q_reg.cnt == 8'hFF)
        q_next.ovfPulse = 1'b1; // RULE2
    end

    // location writes, direct or through the pointer
    if (wEn) begin
      case (wLoc)
        6'h00: ;
        `PST_LOC_CNT: begin
          q_next.cnt = wDat; // RULE4
          q_next.pre = 8'h00; // RULE6
        end
        `PST_LOC_PCL: begin
          launch = 1'b1;
          nOp = OP_PCWR;
          nArg = {2'h0, wDat};
        end
        `PST_LOC_STAT: statClr = wDat[`PST_ST_OVF];
        `PST_LOC_PTR: q_next.ptr = wDat[5:0]; // RULE19
        default: q_next.ram[wLoc] = wDat; // RULE1
      endcase
    end
    // a wrap in the clearing cycle keeps the flag set
    q_next.ovf = (q_reg.ovf && !statClr) || q_next.ovfPulse;

    // sequencer; a request while busy is dropped
    spUp = spStep(q_reg.sp, 1'b1);
    spDn = spStep(q_reg.sp, 1'b0);
    retTgt = q_reg.stk[spDn];
    sum = q_reg.pc + 10'h001 + {2'h0, q_reg.arg[7:0]};
    case (q_reg.st)
      ST_IDLE: begin
        if (launch) begin
          q_next.st = ST_EXEC;
          q_next.op = nOp;
          q_next.arg = nArg;
          q_next.cyc = (nOp == OP_NOP) ? `PST_CYC_PLAIN
                                       : `PST_CYC_BRANCH; // RULE18
        end
      end
      ST_EXEC: begin
        if (tick) begin
          q_next.cyc = q_reg.cyc - 2'h1; // RULE17
          if (q_reg.cyc == 2'h1) begin
            doExec = 1'b1;
            q_next.st = ST_IDLE;
          end
        end
      end
      default: q_next.st = ST_IDLE;
    endcase
    if (doExec) begin
      case (q_reg.op)
        OP_NOP: q_next.pc = q_reg.pc + 10'h001; // RULE8
        OP_JUMP: q_next.pc = q_reg.arg; // RULE11
        OP_CALL: begin
          q_next.stk[q_reg.sp] = q_reg.pc + 10'h001; // RULE12
          q_next.sp = spUp; // RULE14
          q_next.pc = q_reg.arg;
        end
        OP_RET, OP_RETINT: begin
          q_next.pc = retTgt; // RULE13
          q_next.sp = spDn;
        end
        OP_RETLIT: begin
          q_next.pc = retTgt; // RULE13
          q_next.sp = spDn;
          q_next.lit = q_reg.arg[7:0];
        end
        OP_PCWR: q_next.pc = pcFix({q_reg.pc[9:8], q_reg.arg[7:0]});
        OP_PCADD: q_next.pc = pcFix(sum); // RULE16
        default: ;
      endcase
    end

    // read channel
    if (q_reg.rValid && s_axi_rready)
      q_next.rValid = 1'b0;
    case (s_axi_araddr[4:2])
      `PST_IDX_IND: rdVal = {24'h0, rdLoc(q_reg.ptr)}; // RULE1
      `PST_IDX_TSET: rdVal = {24'h0, q_reg.tset};
      `PST_IDX_CMD: rdVal = {19'h0, q_reg.op, q_reg.arg};
      `PST_IDX_PCF: rdVal = {q_reg.lit, 5'h00, q_reg.sp, 6'h00, q_reg.pc};
      default: rdVal = {24'h0, rdLoc({3'h0, s_axi_araddr[4:2]})};
    endcase
    if (s_axi_arvalid && q_reg.arRdy) begin
      q_next.rValid = 1'b1;
      if (s_axi_araddr[31:5] != 27'h0) begin
        q_next.rData = 32'h0000_0000;
        q_next.rResp = `PST_RESP_SLVERR;
      end else begin
        q_next.rData = rdVal;
        q_next.rResp = `PST_RESP_OKAY;
      end
    end
    q_next.awRdy = !q_next.awHeld;
    q_next.wRdy = !q_next.wHeld;
    q_next.arRdy = !q_next.rValid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= '0;
      q_reg.st <= ST_IDLE;
      q_reg.pc <= CORE_TYPE ? `PST_PC_RST_T1 : `PST_PC_RST_T0; // RULE9 RULE10
      q_reg.tset <= `PST_TSET_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  assign s_axi_awready = q_reg.awRdy;
  assign s_axi_wready = q_reg.wRdy;
  assign s_axi_bvalid = q_reg.bValid;
  assign s_axi_bresp = q_reg.bResp;
  assign s_axi_arready = q_reg.arRdy;
  assign s_axi_rvalid = q_reg.rValid;
  assign s_axi_rdata = q_reg.rData;
  assign s_axi_rresp = q_reg.rResp;
  assign pcOut = q_reg.pc; // RULE7
  assign ovfEvent = q_reg.ovfPulse;
  assign busy = q_reg.st[1]; // one-hot execute bit, straight from a flop

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_reset_pc_zero: // RULE9
    assert property ($fell(rst) && CORE_TYPE |-> q_reg.pc == 10'h000)
    else $error("pc not zero after reset");
  a_reset_pc_ones: // RULE10
    assert property ($fell(rst) && !CORE_TYPE |-> q_reg.pc == 10'h3FF)
    else $error("pc not 3FF after reset");
  a_wrap_event: // RULE22
    assert property (q_reg.ovfPulse |->
                     q_reg.cnt == 8'h00 && $past(q_reg.cnt) == 8'hFF)
    else $error("overflow event without wrap");
  a_jump_load: // RULE11
    assert property (doExec && q_reg.op == OP_JUMP |=>
                     q_reg.pc == $past(q_reg.arg))
    else $error("jump target not loaded");
  a_call_push: // RULE12
    assert property (doExec && q_reg.op == OP_CALL |=>
                     q_reg.stk[$past(q_reg.sp)] == $past(q_reg.pc) + 10'h001
                     && q_reg.pc == $past(q_reg.arg))
    else $error("call did not push return address");
  a_return_pop: // RULE13
    assert property (doExec && (q_reg.op == OP_RET ||
                     q_reg.op == OP_RETLIT || q_reg.op == OP_RETINT) |=>
                     q_reg.pc == $past(retTgt) && q_reg.sp == $past(spDn))
    else $error("return did not pop stack");
  a_enh_clear: // RULE15
    assert property (CORE_TYPE && ENH_JUMP && doExec &&
                     (q_reg.op == OP_PCWR || q_reg.op == OP_PCADD) |=>
                     q_reg.pc[9:8] == 2'h0)
    else $error("pc upper bits not cleared");
  a_extra_cycle: // RULE18
    assert property (q_reg.st == ST_EXEC && tick &&
                     q_reg.cyc == `PST_CYC_BRANCH |=>
                     q_reg.st == ST_EXEC && q_reg.cyc == 2'h1)
    else $error("branch finished in one cycle");
  a_pre_cleared: // RULE6
    assert property (cntWr |=> q_reg.pre == 8'h00 &&
                     q_reg.cnt == $past(wDat))
    else $error("counter write did not clear prescaler");
  a_stack_range: // RULE14
    assert property (q_reg.sp < `PST_STK_DEPTH)
    else $error("stack pointer out of range");
  a_ptr_upper: // RULE19
    assert property (s_axi_arvalid && q_reg.arRdy &&
                     s_axi_araddr == 32'h0000_0010 |=>
                     s_axi_rdata[7:6] == 2'h3)
    else $error("pointer upper bits not one");
  a_div_range: // RULE17
    assert property ({1'b0, q_reg.divCnt} < 4'(CLK_DIV))
    else $error("divider out of range");

  c_call_done: cover property (doExec && q_reg.op == OP_CALL);
  c_stack_wrap: cover property (doExec && q_reg.op == OP_CALL &&
                                q_reg.sp == 3'h4);
  c_counter_wrap: cover property (q_reg.ovfPulse);
  c_return_lit: cover property (doExec && q_reg.op == OP_RETLIT);
endmodule

/* tb/testbench.sv */
// self-checking bench of the program sequencer and timer
`timescale 1ns/100ps
module testbench;
  import pst_pkg::*;
  localparam int DIV = 2;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic tccPin = 1'h0;
  logic [31:0] awAddr = 32'h0;
  logic [31:0] wData = 32'h0;
  logic [31:0] arAddr = 32'h0;
  logic [3:0] wStrb = 4'hF;
  logic awValid = 1'h0;
  logic wValid = 1'h0;
  logic bReady = 1'h0;
  logic arValid = 1'h0;
  logic rReady = 1'h0;
  logic awReady, wReady, bValid, arReady, rValid, ovfEvent, busy;
  logic [1:0] bResp, rResp, rs;
  logic [31:0] rData, rv;
  pst_pc_t pcOut, pcAlt;
  int fails = 0;
  int n_checks = 0;
  int run = 0;
  int lastLen = 0;
  int t;

  pst_core #(.CORE_TYPE(1'h1), .ENH_JUMP(1'h1), .CLK_DIV(DIV)) pst_core_i (
    .clk(clk), .rst(rst), .tccPin(tccPin), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .pcOut(pcOut), .ovfEvent(ovfEvent),
    .busy(busy));
  // type zero twin on the same bus; only its program counter is watched
  pst_core #(.CORE_TYPE(1'h0), .ENH_JUMP(1'h1), .CLK_DIV(DIV)) pst_core_i2 (
    .clk(clk), .rst(rst), .tccPin(tccPin), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready(rReady), .pcOut(pcAlt), .ovfEvent(), .busy());

  initial begin
    forever #50 clk = ~clk;
  end

  // length of the last busy span, independent of when a task looks
  always @(posedge clk) begin
    if (busy === 1'h1) begin
      run <= run + 1;
    end else if (run != 0) begin
      lastLen <= run;
      run <= 0;
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g,
                     input string w);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    awAddr <= a;
    wData <= d;
    awValid <= 1'h1;
    wValid <= 1'h1;
    bReady <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awValid && awReady) awValid <= 1'h0;
      if (wValid && wReady) wValid <= 1'h0;
    end while (bValid !== 1'h1 && n < 200);
    r = bResp;
    // bready stays up between writes, so no step assigns it twice
    if (n >= 200) fails++;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    arAddr <= a;
    arValid <= 1'h1;
    rReady <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arValid && arReady) arValid <= 1'h0;
    end while (rValid !== 1'h1 && n < 200);
    d = rData;
    r = rResp;
    // rready stays up between reads, so no step assigns it twice
    if (n >= 200) fails++;
  endtask

  task automatic wrc(input logic [31:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk(32'h0, {30'h0, rs}, "write resp");
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e,
                     input string w);
    rd(a, rv, rs);
    chk(32'h0, {30'h0, rs}, "read resp");
    chk(e, rv, w);
  endtask

  // short busy for a step, two instruction cycles for a pc change
  task automatic op(input logic [31:0] a, input logic [12:0] d,
                    input bit plain, input logic [9:0] e);
    int n;
    logic ok;
    wrc(a, {19'h0, d});
    n = 0;
    while (busy !== 1'h1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    while (busy !== 1'h0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    ok = plain ? (lastLen >= 1 && lastLen <= DIV)
               : (lastLen > DIV && lastLen <= 2 * DIV);
    chk(32'h1, {31'h0, ok}, "busy length");
    chk({22'h0, e}, {22'h0, pcOut}, "pc");
  endtask

  task automatic pulse();
    tccPin <= 1'h1;
    repeat (4) @(posedge clk);
    tccPin <= 1'h0;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(32'h0, {22'h0, pcOut}, "pc reset");
    chk(32'h3FF, {22'h0, pcAlt}, "pc reset type0");
    rdc(32'h0C, 32'h0C, "status");
    wrc(32'h10, 32'h05);
    rdc(32'h10, 32'hC5, "pointer");
    wrc(32'h10, 32'h25);
    wrc(32'h00, 32'hA5);
    rdc(32'h00, 32'hA5, "indirect ram");
    wrc(32'h10, 32'h04);
    rdc(32'h00, 32'hC4, "indirect pointer");
    wrc(32'h14, 32'h28);
    rdc(32'h14, 32'h28, "timer setup");
    wrc(32'h10, 32'h01);
    wrc(32'h00, 32'h5A);
    rdc(32'h04, 32'h5A, "counter load");
    repeat (3) pulse();
    rdc(32'h04, 32'h5D, "rising pin");
    wrc(32'h14, 32'h38);
    wrc(32'h04, 32'h00);
    repeat (2) pulse();
    rdc(32'h04, 32'h02, "falling pin");
    wrc(32'h14, 32'h00);
    wrc(32'h04, 32'hFE);
    t = 0;
    while (ovfEvent !== 1'h1 && t < 40) begin
      @(posedge clk);
      t++;
    end
    chk(32'h1, {31'h0, ovfEvent}, "overflow pulse");
    @(posedge clk);
    chk(32'h0, {31'h0, ovfEvent}, "pulse end");
    rdc(32'h0C, 32'h0D, "sticky flag");
    wrc(32'h0C, 32'h01);
    rdc(32'h0C, 32'h0C, "flag cleared");
    // a read in between must leave the prescaler count alone
    wrc(32'h14, 32'h07);
    wrc(32'h04, 32'h00);
    repeat (400) @(posedge clk);
    rdc(32'h04, 32'h00, "ratio early");
    repeat (200) @(posedge clk);
    rdc(32'h04, 32'h01, "ratio step");
    wrc(32'h14, 32'h28);
    op(32'h18, {3'h1, 10'h2AB}, 1'h0, 10'h2AB);
    op(32'h18, {3'h0, 10'h000}, 1'h1, 10'h2AC);
    for (int i = 0; i < 6; i++) begin
      op(32'h18, {3'h2, 10'h300 + 10'(i)}, 1'h0,
         10'h300 + 10'(i));
    end
    // sixth call has overwritten the oldest return address
    for (int i = 0; i < 5; i++) begin
      op(32'h18, {3'(3 + i % 3), 10'h05A}, 1'h0,
         10'h305 - 10'(i));
    end
    op(32'h18, {3'h1, 10'h0FF}, 1'h0, 10'h0FF);
    op(32'h18, {3'h7, 10'h010}, 1'h0, 10'h010);
    chk(32'h110, {22'h0, pcAlt}, "carry add");
    op(32'h18, {3'h1, 10'h3FF}, 1'h0, 10'h3FF);
    op(32'h18, {3'h6, 10'h0AB}, 1'h0, 10'h0AB);
    op(32'h18, {3'h1, 10'h3FF}, 1'h0, 10'h3FF);
    op(32'h08, 13'h00C3, 1'h0, 10'h0C3);
    // a command with only the low byte strobed is dropped
    wStrb <= 4'h1;
    wrc(32'h18, {19'h0, 3'h1, 10'h155});
    repeat (8) @(posedge clk);
    chk(32'h0C3, {22'h0, pcOut}, "half command");
    wStrb <= 4'hF;
    wr(32'h40, 32'h1, rs);
    chk(32'h2, {30'h0, rs}, "bad write resp");
    rd(32'h40, rv, rs);
    chk(32'h2, {30'h0, rs}, "bad read resp");
    chk(32'h0, rv, "bad read data");
    give_verdict();
  end

  // the whole sequence needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule
